// *** rtl/seil_top.sv ***
// Event detection, interrupt flags and control registers of the sensor
// Behaviour
// - Pressure thresholds unsigned, 0.02 mbar per count
// - Select one: altitude thresholds, signed metres
// - Select bit chooses pressure or altitude result
// - Middle and lower follow the same format
// - Temperature thresholds signed eight-bit whole degrees
// - Inconsistent thresholds set the threshold error flag
// - Ready events raised when a result completes
// - Traversal event when middle threshold crossed
// - Window event when value outside upper/lower band
// - Six flags active high, sticky until cleared
// - Read or convert command clears pending flags
// - One enable bit per interrupt
// - One routing bit per interrupt onto pin
// - Enabled unrouted flag shows, pin unaffected
// - Device ready only while idle asleep
// - Compensation bit selects compensated or raw output
// - Enable, routing, status at consecutive addresses
module seil_top #(
	parameter int RESULT_W = seil_pkg::RESULT_W
) (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire logic                  ce,
	input  wire logic [7:0]            reg_addr,
	input  wire logic                  reg_wr_en,
	input  wire logic [7:0]            reg_wr_data,
	input  wire logic                  reg_rd_en,
	output logic      [7:0]            reg_rd_data,
	output logic                       reg_rd_valid,
	input  wire logic [15:0]           pressure_value,
	input  wire logic [15:0]           altitude_value,
	input  wire logic                  pa_result_valid,
	input  wire logic [7:0]            temperature_value,
	input  wire logic                  t_result_valid,
	input  wire logic                  cmd_read_result,
	input  wire logic                  cmd_start_conv,
	input  wire logic                  sleep_state,
	input  wire logic                  powerup_busy,
	input  wire logic                  conv_busy,
	input  wire logic                  cmd_busy,
	input  wire logic [RESULT_W-1:0]   raw_data,
	input  wire logic [RESULT_W-1:0]   comp_data,
	output logic      [RESULT_W-1:0]   result_data,
	output logic                       pressure_altitude_select,
	output logic                       compensation_enable,
	output logic                       interrupt_one_pin
);

	localparam int DW = seil_pkg::DATA_W;
	localparam int TD = seil_pkg::TH_DEPTH;
	localparam int NE = seil_pkg::N_EVENTS;

	logic [TD*DW-1:0]    th_bytes;
	logic [7:0]          th_rd_data;
	logic [7:0]          th_idx;
	logic                th_hit;

	logic [NE-1:0]       irq_enable_mask_reg;
	logic [NE-1:0]       irq_enable_mask_next;
	logic [NE-1:0]       irq_route_reg;
	logic [NE-1:0]       irq_route_next;
	logic                pa_select_reg;
	logic                pa_select_next;
	logic                comp_en_reg;
	logic                comp_en_next;

	logic [NE-1:0]       flags_reg;
	logic [NE-1:0]       flags_next;
	logic [NE-1:0]       ev_set;
	logic                flag_clear;
	logic                threshold_error_flag_reg;
	logic                threshold_error_flag_next;
	logic                device_ready_flag_reg;
	logic                device_ready_flag_next;
	logic                pin_reg;
	logic                pin_next;
	logic [RESULT_W-1:0] result_reg;
	logic [RESULT_W-1:0] result_next;

	logic                rd_pend_reg;
	logic                rd_pend_next;
	logic                rd_from_mem_reg;
	logic                rd_from_mem_next;
	logic [7:0]          rd_own_reg;
	logic [7:0]          rd_own_next;
	logic [7:0]          rd_data_reg;
	logic [7:0]          rd_data_next;
	logic                rd_valid_reg;
	logic                rd_valid_next;

	logic [15:0]         pa_upper;
	logic [15:0]         pa_middle;
	logic [15:0]         pa_lower;
	logic [7:0]          t_upper;
	logic [7:0]          t_middle;
	logic [7:0]          t_lower;
	logic [15:0]         pa_value;
	logic                pressure_window_event_hit;
	logic                pressure_traversal_event_hit;
	logic                pa_err;
	logic                temperature_window_event_hit;
	logic                temperature_traversal_event_hit;
	logic                t_err;
	logic                mode_change;

	assign th_hit = reg_addr >= seil_pkg::ADDR_TH_FIRST &&
		reg_addr <= seil_pkg::ADDR_TH_LAST;
	assign th_idx = reg_addr - seil_pkg::ADDR_TH_FIRST;

	seil_regfile #(
		.DEPTH (TD),
		.W     (DW)
	) u_thr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.wr_en   (reg_wr_en && th_hit),
		.wr_idx  (th_idx),
		.wr_data (reg_wr_data),
		.rd_idx  (th_hit ? th_idx : 8'hFF),
		.rd_data (th_rd_data),
		.entries (th_bytes)
	);

	assign pa_upper  = {th_bytes[seil_pkg::IDX_PA_UP_HI*DW +: DW],
		th_bytes[seil_pkg::IDX_PA_UP_LO*DW +: DW]};
	// same layout for middle and lower
	assign pa_middle = {th_bytes[seil_pkg::IDX_PA_MI_HI*DW +: DW],
		th_bytes[seil_pkg::IDX_PA_MI_LO*DW +: DW]};
	assign pa_lower  = {th_bytes[seil_pkg::IDX_PA_LO_HI*DW +: DW],
		th_bytes[seil_pkg::IDX_PA_LO_LO*DW +: DW]};
	assign t_upper   = th_bytes[seil_pkg::IDX_T_UP*DW +: DW];
	assign t_middle  = th_bytes[seil_pkg::IDX_T_MI*DW +: DW];
	assign t_lower   = th_bytes[seil_pkg::IDX_T_LO*DW +: DW];

	assign pa_value = pa_select_reg ? altitude_value : pressure_value;
	assign mode_change = reg_wr_en &&
		reg_addr == seil_pkg::ADDR_IRQ_ROUTE &&
		reg_wr_data[seil_pkg::BIT_PA_SELECT] != pa_select_reg;

	seil_cmp #(
		.W (seil_pkg::PA_W)
	) u_cmp_pa (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.ce          (ce),
		.is_signed   (pa_select_reg),
		.sample      (pa_result_valid),
		.restart     (mode_change),
		.value       (pa_value),
		.upper       (pa_upper),
		.middle      (pa_middle),
		.lower       (pa_lower),
		.window_hit  (pressure_window_event_hit),
		.trav_hit    (pressure_traversal_event_hit),
		.setting_err (pa_err)
	);

	seil_cmp #(
		.W (seil_pkg::T_W)
	) u_cmp_t (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.ce          (ce),
		.is_signed   (1'b1),
		.sample      (t_result_valid),
		.restart     (1'b0),
		.value       (temperature_value),
		.upper       (t_upper),
		.middle      (t_middle),
		.lower       (t_lower),
		.window_hit  (temperature_window_event_hit),
		.trav_hit    (temperature_traversal_event_hit),
		.setting_err (t_err)
	);

	// Control registers
	always_comb begin
		irq_enable_mask_next = irq_enable_mask_reg;
		irq_route_next       = irq_route_reg;
		pa_select_next       = pa_select_reg;
		comp_en_next         = comp_en_reg;
		if (ce && reg_wr_en) begin
			unique case (reg_addr)
				seil_pkg::ADDR_IRQ_ENABLE: begin
					irq_enable_mask_next = reg_wr_data[NE-1:0];
				end
				seil_pkg::ADDR_IRQ_ROUTE: begin
					irq_route_next = reg_wr_data[NE-1:0];
					pa_select_next =
						reg_wr_data[seil_pkg::BIT_PA_SELECT];
				end
				seil_pkg::ADDR_COMP_CTRL: begin
					comp_en_next = reg_wr_data[seil_pkg::BIT_COMP_EN];
				end
				// Status and unmapped writes are dropped
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_enable_mask_reg <= seil_pkg::EV_NONE;
			irq_route_reg       <= seil_pkg::EV_NONE;
			pa_select_reg       <= seil_pkg::RST_ZERO[seil_pkg::BIT_PA_SELECT];
			comp_en_reg <= seil_pkg::RST_COMP_CTRL[seil_pkg::BIT_COMP_EN];
		end else begin
			irq_enable_mask_reg <= irq_enable_mask_next;
			irq_route_reg       <= irq_route_next;
			pa_select_reg       <= pa_select_next;
			comp_en_reg         <= comp_en_next;
		end
	end

	// Event sources
	always_comb begin
		ev_set = seil_pkg::EV_NONE;
		ev_set[seil_pkg::EV_PRESSURE_READY_EVENT]  = pa_result_valid;
		ev_set[seil_pkg::EV_T_RDY]   = t_result_valid;
		ev_set[seil_pkg::EV_PRESSURE_TRAVERSAL_EVENT] = pa_result_valid && pressure_traversal_event_hit;
		ev_set[seil_pkg::EV_TEMPERATURE_TRAVERSAL_EVENT]  = t_result_valid && temperature_traversal_event_hit;
		ev_set[seil_pkg::EV_PRESSURE_WINDOW_EVENT]  = pa_result_valid && pressure_window_event_hit;
		ev_set[seil_pkg::EV_TEMPERATURE_WINDOW_EVENT]   = t_result_valid && temperature_window_event_hit;
	end

	assign flag_clear = cmd_read_result || cmd_start_conv;

	genvar i;
	generate
		for (i = 0; i < NE; i++) begin : g_flag
			// sticky flag, a new event beats the clear
			always_comb begin
				flags_next[i] = flags_reg[i];
				if (ce) begin
					if (ev_set[i] && irq_enable_mask_reg[i])
						flags_next[i] = 1'b1;
					else if (flag_clear)
						flags_next[i] = 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		threshold_error_flag_next = threshold_error_flag_reg;
		device_ready_flag_next    = device_ready_flag_reg;
		pin_next                  = pin_reg;
		result_next               = result_reg;
		if (ce) begin
			threshold_error_flag_next = pa_err || t_err;
			device_ready_flag_next = sleep_state && !powerup_busy &&
				!conv_busy && !cmd_busy;
			// unrouted flags never reach the pin
			pin_next = |(flags_next & irq_route_reg);
			result_next = comp_en_reg ? comp_data : raw_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flags_reg                <= seil_pkg::EV_NONE;
			threshold_error_flag_reg <= 1'b0;
			device_ready_flag_reg    <= 1'b0;
			pin_reg                  <= 1'b0;
			result_reg               <= '0;
		end else begin
			flags_reg                <= flags_next;
			threshold_error_flag_reg <= threshold_error_flag_next;
			device_ready_flag_reg    <= device_ready_flag_next;
			pin_reg                  <= pin_next;
			result_reg               <= result_next;
		end
	end

	// Read path: two cycles, matching the threshold memory latency
	always_comb begin
		rd_pend_next     = rd_pend_reg;
		rd_from_mem_next = rd_from_mem_reg;
		rd_own_next      = rd_own_reg;
		rd_data_next     = rd_data_reg;
		rd_valid_next    = rd_valid_reg;
		if (ce) begin
			rd_pend_next     = reg_rd_en;
			rd_from_mem_next = th_hit;
			rd_own_next      = seil_pkg::RST_ZERO;
			unique case (reg_addr)
				seil_pkg::ADDR_IRQ_ENABLE: begin
					rd_own_next[NE-1:0] = irq_enable_mask_reg;
				end
				seil_pkg::ADDR_IRQ_ROUTE: begin
					rd_own_next[NE-1:0] = irq_route_reg;
					rd_own_next[seil_pkg::BIT_PA_SELECT] = pa_select_reg;
				end
				seil_pkg::ADDR_IRQ_FLAGS: begin
					rd_own_next[NE-1:0] = flags_reg;
					rd_own_next[seil_pkg::BIT_DEV_READY] =
						device_ready_flag_reg;
					rd_own_next[seil_pkg::BIT_TH_ERROR] =
						threshold_error_flag_reg;
				end
				seil_pkg::ADDR_COMP_CTRL: begin
					rd_own_next[seil_pkg::BIT_COMP_EN] = comp_en_reg;
				end
				default: begin
				end
			endcase
			rd_valid_next = rd_pend_reg;
			if (rd_pend_reg)
				rd_data_next = rd_from_mem_reg ? th_rd_data : rd_own_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_pend_reg     <= 1'b0;
			rd_from_mem_reg <= 1'b0;
			rd_own_reg      <= seil_pkg::RST_ZERO;
			rd_data_reg     <= seil_pkg::RST_ZERO;
			rd_valid_reg    <= 1'b0;
		end else begin
			rd_pend_reg     <= rd_pend_next;
			rd_from_mem_reg <= rd_from_mem_next;
			rd_own_reg      <= rd_own_next;
			rd_data_reg     <= rd_data_next;
			rd_valid_reg    <= rd_valid_next;
		end
	end

	assign reg_rd_data              = rd_data_reg;
	assign reg_rd_valid             = rd_valid_reg;
	assign result_data              = result_reg;
	assign pressure_altitude_select = pa_select_reg;
	assign compensation_enable      = comp_en_reg;
	assign interrupt_one_pin        = pin_reg;

	a_pa_ready_set: assert property (@(posedge clk) disable iff (sys_rst)
		ce && pa_result_valid && irq_enable_mask_reg[seil_pkg::EV_PRESSURE_READY_EVENT]
		|=> flags_reg[seil_pkg::EV_PRESSURE_READY_EVENT])
		else $error("pressure ready flag not set");

	a_flags_cleared: assert property (@(posedge clk) disable iff (sys_rst)
		ce && flag_clear && !pa_result_valid && !t_result_valid
		|=> flags_reg == seil_pkg::EV_NONE)
		else $error("flags not cleared by command");

	a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(flags_reg[seil_pkg::EV_T_RDY]) |-> $past(ce) && $past(flag_clear))
		else $error("flag dropped without clear");

	a_disabled_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!irq_enable_mask_reg[seil_pkg::EV_PRESSURE_WINDOW_EVENT] &&
		!flags_reg[seil_pkg::EV_PRESSURE_WINDOW_EVENT] && !reg_wr_en
		|=> !flags_reg[seil_pkg::EV_PRESSURE_WINDOW_EVENT])
		else $error("disabled flag became set");

	a_pin_routed: assert property (@(posedge clk) disable iff (sys_rst)
		ce && (flags_reg & irq_route_reg) != seil_pkg::EV_NONE &&
		!flag_clear && !reg_wr_en |=> interrupt_one_pin)
		else $error("routed flag missing on pin");

	a_pin_unrouted: assert property (@(posedge clk) disable iff (sys_rst)
		ce && (flags_reg & irq_route_reg) == seil_pkg::EV_NONE &&
		!pa_result_valid && !t_result_valid && !reg_wr_en
		|=> !interrupt_one_pin)
		else $error("pin raised by unrouted flag");

	a_ready_busy: assert property (@(posedge clk) disable iff (sys_rst)
		ce && (conv_busy || !sleep_state) |=> !device_ready_flag_reg)
		else $error("device ready while busy");

	a_comp_output: assert property (@(posedge clk) disable iff (sys_rst)
		ce && comp_en_reg |=> result_data == $past(comp_data))
		else $error("compensated data not selected");

	a_th_error: assert property (@(posedge clk) disable iff (sys_rst)
		ce && !pa_select_reg && pa_lower > pa_upper
		|=> threshold_error_flag_reg)
		else $error("threshold error not flagged");

	a_win_event: assert property (@(posedge clk) disable iff (sys_rst)
		ce && pa_result_valid && !pa_select_reg &&
		irq_enable_mask_reg[seil_pkg::EV_PRESSURE_WINDOW_EVENT] && pa_value > pa_upper
		|=> flags_reg[seil_pkg::EV_PRESSURE_WINDOW_EVENT])
		else $error("window event missed");

	a_trav_event: assert property (@(posedge clk) disable iff (sys_rst)
		ce && t_result_valid && temperature_traversal_event_hit &&
		irq_enable_mask_reg[seil_pkg::EV_TEMPERATURE_TRAVERSAL_EVENT]
		|=> flags_reg[seil_pkg::EV_TEMPERATURE_TRAVERSAL_EVENT])
		else $error("traversal event missed");

	a_enable_read: assert property (@(posedge clk) disable iff (sys_rst)
		ce && reg_rd_en && reg_addr == seil_pkg::ADDR_IRQ_ENABLE ##1 ce
		|=> reg_rd_valid && reg_rd_data[7:6] == 2'h0)
		else $error("enable register read wrong");

endmodule

// *** rtl/seil_pkg.sv ***
// Shared constants for the sensor event interrupt logic
package seil_pkg;

	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 8;
	localparam int PA_W     = 16;
	localparam int T_W      = 8;
	localparam int RESULT_W = 48;

	// Register addresses
	localparam logic [7:0] ADDR_TH_FIRST   = 8'h02;
	localparam logic [7:0] ADDR_TH_LAST    = 8'h0A;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0B;
	localparam logic [7:0] ADDR_IRQ_ROUTE  = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'h0D;
	localparam logic [7:0] ADDR_COMP_CTRL  = 8'h0F;

	// Threshold byte slots, counted from ADDR_TH_FIRST
	localparam int TH_DEPTH     = 9;
	localparam int IDX_PA_UP_LO = 0;
	localparam int IDX_PA_UP_HI = 1;
	localparam int IDX_PA_MI_LO = 2;
	localparam int IDX_PA_MI_HI = 3;
	localparam int IDX_PA_LO_LO = 4;
	localparam int IDX_PA_LO_HI = 5;
	localparam int IDX_T_UP     = 6;
	localparam int IDX_T_MI     = 7;
	localparam int IDX_T_LO     = 8;

	// Event bit positions in enable, routing and flag registers
	localparam int N_EVENTS   = 6;
	localparam int EV_TEMPERATURE_WINDOW_EVENT   = 0;
	localparam int EV_PRESSURE_WINDOW_EVENT  = 1;
	localparam int EV_TEMPERATURE_TRAVERSAL_EVENT  = 2;
	localparam int EV_PRESSURE_TRAVERSAL_EVENT = 3;
	localparam int EV_T_RDY   = 4;
	localparam int EV_PRESSURE_READY_EVENT  = 5;

	localparam int BIT_PA_SELECT = 6;
	localparam int BIT_DEV_READY = 6;
	localparam int BIT_TH_ERROR  = 7;
	localparam int BIT_COMP_EN   = 7;

	// Reset values
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_COMP_CTRL = 8'h80;
	localparam logic [5:0] EV_NONE       = 6'h00;

endpackage

// *** rtl/seil_regfile.sv ***
// Threshold byte storage with registered read port
module seil_regfile #(
	parameter int DEPTH = seil_pkg::TH_DEPTH,
	parameter int W     = seil_pkg::DATA_W
) (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               ce,
	input  wire logic               wr_en,
	input  wire logic [7:0]         wr_idx,
	input  wire logic [W-1:0]       wr_data,
	input  wire logic [7:0]         rd_idx,
	output logic      [W-1:0]       rd_data,
	output logic      [DEPTH*W-1:0] entries
);

	logic [W-1:0] rd_data_reg;
	logic [W-1:0] rd_data_next;

	genvar k;
	generate
		for (k = 0; k < DEPTH; k++) begin : g_entry
			logic [W-1:0] ent_reg;
			logic [W-1:0] ent_next;
			always_comb begin
				ent_next = ent_reg;
				if (ce && wr_en && wr_idx == 8'(k))
					ent_next = wr_data;
			end
			always_ff @(posedge clk) begin
				if (sys_rst)
					ent_reg <= '0;
				else
					ent_reg <= ent_next;
			end
			assign entries[k*W +: W] = ent_reg;
		end
	endgenerate

	// Out-of-range index reads as zero
	always_comb begin
		rd_data_next = rd_data_reg;
		if (ce)
			rd_data_next = (rd_idx < 8'(DEPTH)) ?
				entries[rd_idx*W +: W] : '0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			rd_data_reg <= '0;
		else
			rd_data_reg <= rd_data_next;
	end

	assign rd_data = rd_data_reg;

endmodule

// *** rtl/seil_cmp.sv ***
// Window, traversal and setting checks for one measured quantity
module seil_cmp #(
	parameter int W = seil_pkg::PA_W
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic         ce,
	input  wire logic         is_signed,
	input  wire logic         sample,
	input  wire logic         restart,
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] upper,
	input  wire logic [W-1:0] middle,
	input  wire logic [W-1:0] lower,
	output logic              window_hit,
	output logic              trav_hit,
	output logic              setting_err
);

	logic [W-1:0] prev_reg;
	logic [W-1:0] prev_next;
	logic         prev_ok_reg;
	logic         prev_ok_next;

	// Flipping the sign bit turns a signed compare into an unsigned one
	function automatic logic gt(input logic [W-1:0] a,
		input logic [W-1:0] b, input logic sgn);
		logic [W-1:0] flip;
		flip = {sgn, {(W-1){1'b0}}};
		return (a ^ flip) > (b ^ flip);
	endfunction

	always_comb begin
		window_hit  = gt(value, upper, is_signed) ||
			gt(lower, value, is_signed);
		trav_hit    = prev_ok_reg &&
			(gt(middle, prev_reg, is_signed) !=
			gt(middle, value, is_signed));
		setting_err = gt(lower, upper, is_signed) ||
			gt(middle, upper, is_signed) ||
			gt(lower, middle, is_signed);
	end

	// A format change makes the stored sample meaningless
	always_comb begin
		prev_next    = prev_reg;
		prev_ok_next = prev_ok_reg;
		if (ce) begin
			if (restart) begin
				prev_ok_next = 1'b0;
			end else if (sample) begin
				prev_next    = value;
				prev_ok_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_reg    <= '0;
			prev_ok_reg <= 1'b0;
		end else begin
			prev_reg    <= prev_next;
			prev_ok_reg <= prev_ok_next;
		end
	end

endmodule

// *** test/seil_host.sv ***
// Host side model: register bus, clearing commands, status polling
module seil_host (
	input  wire logic       clk,
	input  wire logic       reg_rd_valid,
	input  wire logic [7:0] reg_rd_data,
	output logic      [7:0] reg_addr,
	output logic            reg_wr_en,
	output logic      [7:0] reg_wr_data,
	output logic            reg_rd_en,
	output logic            cmd_read_result,
	output logic            cmd_start_conv
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en = 1'b0;
		cmd_read_result = 1'b0;
		cmd_start_conv = 1'b0;
	end

	// Idle bus shows inverted values, never the last request
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wr_data = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge clk);
			if (reg_rd_valid === 1'b1) begin
				d = reg_rd_data;
				ok = 1'b1;
			end
		end
	endtask

	task automatic cmd(input logic start);
		@(negedge clk);
		cmd_start_conv = start;
		cmd_read_result = !start;
		@(negedge clk);
		cmd_start_conv = 1'b0;
		cmd_read_result = 1'b0;
	endtask

	task automatic set_irq(input logic [7:0] en, input logic [7:0] route);
		logic [7:0] e;
		e = en | {2'b00, en[3] | en[1], en[2] | en[0], 4'h0};
		wr(8'h0B, e);
		wr(8'h0C, route);
	endtask

	task automatic set_pa(input logic [15:0] up, mid, lo,
		output logic [7:0] st, output logic ok);
		wr(8'h02, up[7:0]);
		wr(8'h03, up[15:8]);
		wr(8'h04, mid[7:0]);
		wr(8'h05, mid[15:8]);
		wr(8'h06, lo[7:0]);
		wr(8'h07, lo[15:8]);
		rd(8'h0D, st, ok);
	endtask

	task automatic wait_ready(output logic ok);
		logic [7:0] d;
		logic       v;
		ok = 1'b0;
		for (int i = 0; i < 8 && !ok; i++) begin
			rd(8'h0D, d, v);
			ok = v & d[6];
		end
	endtask
endmodule

// *** test/tb_seil_top.sv ***
// Self-checking bench for the sensor event interrupt logic
module tb_seil_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        sys_rst;
	logic        ce;
	logic [7:0]  reg_addr;
	logic        reg_wr_en;
	logic [7:0]  reg_wr_data;
	logic        reg_rd_en;
	logic [7:0]  reg_rd_data;
	logic        reg_rd_valid;
	logic [15:0] pressure_value;
	logic [15:0] altitude_value;
	logic        pa_result_valid;
	logic [7:0]  temperature_value;
	logic        t_result_valid;
	logic        cmd_read_result;
	logic        cmd_start_conv;
	logic        sleep_state;
	logic        powerup_busy;
	logic        conv_busy;
	logic        cmd_busy;
	logic [47:0] raw_data;
	logic [47:0] comp_data;
	logic [47:0] result_data;
	logic        pressure_altitude_select;
	logic        compensation_enable;
	logic        interrupt_one_pin;
	logic [7:0]  st;
	logic        ok;
	int          err_total = 0;
	int          cmp_count = 0;

	always #12.5 clk = ~clk;

	seil_top #(.RESULT_W(48)) seil_top_i (.clk, .sys_rst, .ce,
		.reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
		.reg_rd_valid, .pressure_value, .altitude_value, .pa_result_valid,
		.temperature_value, .t_result_valid, .cmd_read_result,
		.cmd_start_conv, .sleep_state, .powerup_busy, .conv_busy,
		.cmd_busy, .raw_data, .comp_data, .result_data,
		.pressure_altitude_select, .compensation_enable,
		.interrupt_one_pin);

	seil_host seil_host_i (.clk, .reg_rd_valid, .reg_rd_data, .reg_addr,
		.reg_wr_en, .reg_wr_data, .reg_rd_en, .cmd_read_result,
		.cmd_start_conv);

	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	task automatic rdc(input logic [7:0] a, exp);
		logic [7:0] d;
		logic       v;
		seil_host_i.rd(a, d, v);
		if (v !== 1'b1) begin
			err_total++;
			$display("BAD %0t read answer missing", $time);
			finish_test();
		end
		chk({40'h0, d}, {40'h0, exp}, "register read");
	endtask

	task automatic pin_is(input logic e);
		chk({47'h0, interrupt_one_pin}, {47'h0, e}, "interrupt pin");
	endtask

	task automatic pa_meas(input logic [15:0] p, alt);
		@(negedge clk);
		pressure_value = p;
		altitude_value = alt;
		pa_result_valid = 1'b1;
		@(negedge clk);
		pa_result_valid = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic t_meas(input logic [7:0] t);
		@(negedge clk);
		temperature_value = t;
		t_result_valid = 1'b1;
		@(negedge clk);
		t_result_valid = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic t_reset;
		rdc(8'h0F, 8'h80);
		rdc(8'h0B, 8'h00);
		seil_host_i.wr(8'h0D, 8'hFF);
		rdc(8'h0D, 8'h00);
		rdc(8'h0E, 8'h00);
		pin_is(1'b0);
		$display("test reset done");
	endtask

	task automatic t_window;
		seil_host_i.set_pa(16'h9C43, 16'h5000, 16'h1000, st, ok);
		chk({39'h0, ok, st}, {40'h1, 8'h00}, "error clear");
		seil_host_i.set_irq(8'h02, 8'h02);
		rdc(8'h0B, 8'h22);
		pa_meas(16'h9C43, 16'h0000);
		pin_is(1'b0);
		rdc(8'h0D, 8'h20);
		seil_host_i.cmd(1'b1);
		rdc(8'h0D, 8'h00);
		pa_meas(16'h9C44, 16'h0000);
		pin_is(1'b1);
		rdc(8'h0D, 8'h22);
		pin_is(1'b1);
		seil_host_i.cmd(1'b0);
		rdc(8'h0D, 8'h00);
		pin_is(1'b0);
		$display("test window done");
	endtask

	task automatic t_unrouted;
		seil_host_i.set_irq(8'h01, 8'h00);
		t_meas(8'h05);
		pin_is(1'b0);
		rdc(8'h0D, 8'h11);
		pa_meas(16'hFFFF, 16'h0000);
		rdc(8'h0D, 8'h11);
		seil_host_i.cmd(1'b1);
		$display("test unrouted done");
	endtask

	task automatic temperature_traversal_event;
		seil_host_i.set_irq(8'h04, 8'h3F);
		t_meas(8'hF6);
		pin_is(1'b1);
		rdc(8'h0D, 8'h14);
		seil_host_i.cmd(1'b0);
		t_meas(8'hF0);
		rdc(8'h0D, 8'h10);
		seil_host_i.cmd(1'b1);
		$display("test traversal done");
	endtask

	task automatic t_alt;
		seil_host_i.set_pa(16'h1388, 16'h0000, 16'hFF00, st, ok);
		chk({39'h0, ok, st}, {40'h1, 8'h80}, "error set");
		seil_host_i.set_irq(8'h02, 8'h40);
		rdc(8'h0D, 8'h00);
		chk({47'h0, pressure_altitude_select}, 48'h1, "select");
		pa_meas(16'hFFFF, 16'h0100);
		rdc(8'h0D, 8'h20);
		pa_meas(16'h0000, 16'hFE00);
		rdc(8'h0D, 8'h22);
		seil_host_i.cmd(1'b1);
		seil_host_i.set_irq(8'h00, 8'h00);
		seil_host_i.set_pa(16'h9C43, 16'h5000, 16'h1000, st, ok);
		$display("test altitude done");
	endtask

	task automatic t_comp;
		raw_data = 48'h5555_6666_7777;
		comp_data = 48'hDDDD_EEEE_FFFF;
		repeat (2) @(negedge clk);
		chk(result_data, comp_data, "compensated");
		seil_host_i.wr(8'h0F, 8'h00);
		repeat (2) @(negedge clk);
		chk(result_data, raw_data, "raw");
		chk({47'h0, compensation_enable}, 48'h0, "comp bit");
		seil_host_i.wr(8'h0F, 8'h80);
		$display("test compensation done");
	endtask

	task automatic t_freeze;
		seil_host_i.wr(8'h0A, 8'h10);
		rdc(8'h0D, 8'h80);
		seil_host_i.wr(8'h0A, 8'hF0);
		rdc(8'h0D, 8'h00);
		seil_host_i.set_irq(8'h20, 8'h20);
		ce = 1'b0;
		pa_meas(16'h0001, 16'h0000);
		seil_host_i.wr(8'h0B, 8'h00);
		ce = 1'b1;
		pin_is(1'b0);
		rdc(8'h0D, 8'h00);
		rdc(8'h0B, 8'h20);
		pa_meas(16'h0001, 16'h0000);
		pin_is(1'b1);
		rdc(8'h0D, 8'h20);
		seil_host_i.cmd(1'b0);
		seil_host_i.set_irq(8'h00, 8'h00);
		$display("test freeze done");
	endtask

	task automatic t_ready;
		sleep_state = 1'b1;
		seil_host_i.wait_ready(ok);
		chk({47'h0, ok}, 48'h1, "device ready");
		for (int i = 0; i < 3; i++) begin
			{powerup_busy, conv_busy, cmd_busy} = 3'b100 >> i;
			rdc(8'h0D, 8'h00);
		end
		$display("test ready done");
	endtask

	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		pressure_value = 16'h0000;
		altitude_value = 16'h0000;
		pa_result_valid = 1'b0;
		temperature_value = 8'h00;
		t_result_valid = 1'b0;
		{sleep_state, powerup_busy, conv_busy, cmd_busy} = 4'h0;
		raw_data = 48'h1111_2222_3333;
		comp_data = 48'hAAAA_BBBB_CCCC;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_window();
		t_unrouted();
		temperature_traversal_event();
		t_alt();
		t_comp();
		t_freeze();
		t_ready();
		finish_test();
	end

	initial begin
		#500000;
		err_total++;
		$display("BAD %0t run limit reached", $time);
		finish_test();
	end
endmodule
